// File: design/psrc_defines.svh
// Purpose: Offsets, field positions and reset values of the reset bank
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef PSRC_DEFINES_SVH
`define PSRC_DEFINES_SVH

// Register byte offsets in the system-control space
`define PSRC_OFF_SERIAL_TIMER 12'h044
`define PSRC_OFF_PORTS_DMA    12'h048
// Reset value of both registers
`define PSRC_RESET_VAL        32'h0000_0000
// Implemented bits of the first register
`define PSRC_BIT_CNT2         18
`define PSRC_BIT_CNT1         17
`define PSRC_BIT_CNT0         16
`define PSRC_BIT_TWOWIRE      12
`define PSRC_BIT_SYNC         4
`define PSRC_BIT_ASYNC        0
`define PSRC_IMPL_ST          32'h0007_1011
// Implemented bits of the second register
`define PSRC_BIT_DMA          13
`define PSRC_BIT_PORT_E       4
`define PSRC_BIT_PORT_D       3
`define PSRC_BIT_PORT_C       2
`define PSRC_BIT_PORT_B       1
`define PSRC_BIT_PORT_A       0
`define PSRC_IMPL_PD          32'h0000_201F

`endif

// File: design/psrc_pkg.sv
// Purpose: Shared types of the peripheral soft reset bank
// Assumes: Nothing
// Notes:   Constants live in psrc_defines.svh
package psrc_pkg;
  // One 32-bit register word
  typedef logic [31:0] psrc_word_t;
  // Register bus address
  typedef logic [11:0] psrc_addr_t;
endpackage : psrc_pkg

// File: design/psrc_reg.sv
// Purpose: One masked software reset control register
// Assumes: Synchronous active-high reset
// Notes:   Write masked by implemented bits and by capability bits
`include "psrc_defines.svh"
module psrc_reg
  import psrc_pkg::*;
#(
  parameter psrc_word_t IMPL = 32'h0000_0000
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire psrc_word_t wr_data,
  input  wire psrc_word_t cap_mask,
  output psrc_word_t      value
);
  psrc_word_t value_q; // Stored bits
  psrc_word_t value_d; // Next value

  // Only present, implemented bits follow the write; others are written as zero
  always_comb begin
    value_d = value_q;
    if (wr_en) begin
      value_d = wr_data & cap_mask & IMPL;
    end
  end

  // Clears to zero on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      value_q <= `PSRC_RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;
endmodule : psrc_reg

// File: design/psrc_top.sv
// Purpose: Software-controlled per-unit reset bank
// Assumes: Strobes one cycle long, never together; 100 MHz CLK
// Notes:   Reset outputs are active high and registered
//          A read in the cycle of a write returns the old word
// Summary of operation
// - Two 32-bit registers, read/write, reset zero
// - Writes masked by capability bits
// - Bits 18..16 reset counters two..zero
// - Bit 12 resets two-wire unit
// - Bit 4 resets synchronous serial unit
// - Bit 0 resets asynchronous serial unit
// - Second register bit 13 resets DMA
// - Second register bits 4..0 reset ports E..A
// - Unassigned bits read-only, read zero
//
// Chosen here: the plain strobed port.
`include "psrc_defines.svh"
module psrc_top
  import psrc_pkg::*;
(
  // Clock and synchronous reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Register bus
  input  wire psrc_addr_t ADDR,
  input  wire psrc_word_t WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output psrc_word_t      RDATA,
  // Capability words, kept outside the bank
  input  wire psrc_word_t CAPABILITY_MASK_SECOND,
  input  wire psrc_word_t CAPABILITY_MASK_FOURTH,
  // One active-high reset line per unit
  output logic            GP_COUNTER_TWO_RESET,
  output logic            GP_COUNTER_ONE_RESET,
  output logic            GP_COUNTER_ZERO_RESET,
  output logic            TWOWIRE_UNIT_RESET,
  output logic            SYNC_SERIAL_RESET,
  output logic            ASYNC_SERIAL_RESET,
  output logic            DMA_UNIT_RESET,
  output logic            PORT_E_RESET,
  output logic            PORT_D_RESET,
  output logic            PORT_C_RESET,
  output logic            PORT_B_RESET,
  output logic            PORT_A_RESET
);
  psrc_word_t st_val;  // Serial/timer register contents
  psrc_word_t pd_val;  // Ports/DMA register contents
  psrc_word_t rdata_q; // Read data, valid the cycle after RD
  logic       wr_st;   // Write hits the first register
  logic       wr_pd;   // Write hits the second register

  // Address decode; unmapped writes are dropped
  assign wr_st = WR && (ADDR == `PSRC_OFF_SERIAL_TIMER);
  assign wr_pd = WR && (ADDR == `PSRC_OFF_PORTS_DMA);

  // First register, masked by the second capability word
  psrc_reg #(
    .IMPL (`PSRC_IMPL_ST)
  ) u_st (
    .clk      (CLK),
    .rst      (RST),
    .wr_en    (wr_st),
    .wr_data  (WDATA),
    .cap_mask (CAPABILITY_MASK_SECOND),
    .value    (st_val)
  );

  // Second register, masked by the fourth capability word
  psrc_reg #(
    .IMPL (`PSRC_IMPL_PD)
  ) u_pd (
    .clk      (CLK),
    .rst      (RST),
    .wr_en    (wr_pd),
    .wr_data  (WDATA),
    .cap_mask (CAPABILITY_MASK_FOURTH),
    .value    (pd_val)
  );

  // Read port; unmapped addresses return zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= `PSRC_RESET_VAL;
    end else if (RD) begin
      case (ADDR)
        `PSRC_OFF_SERIAL_TIMER: rdata_q <= st_val;
        `PSRC_OFF_PORTS_DMA:    rdata_q <= pd_val;
        default:                rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      // Data stand only in the cycle after the read
      rdata_q <= 32'h0000_0000;
    end
  end
  assign RDATA = rdata_q;

  // Reset lines follow the stored bits straight from the flops
  // A held bit keeps its unit in reset until software or RST clears it
  assign GP_COUNTER_TWO_RESET  = st_val[`PSRC_BIT_CNT2];
  assign GP_COUNTER_ONE_RESET  = st_val[`PSRC_BIT_CNT1];
  assign GP_COUNTER_ZERO_RESET = st_val[`PSRC_BIT_CNT0];
  assign TWOWIRE_UNIT_RESET    = st_val[`PSRC_BIT_TWOWIRE];
  assign SYNC_SERIAL_RESET     = st_val[`PSRC_BIT_SYNC];
  assign ASYNC_SERIAL_RESET    = st_val[`PSRC_BIT_ASYNC];
  assign DMA_UNIT_RESET        = pd_val[`PSRC_BIT_DMA];
  assign PORT_E_RESET          = pd_val[`PSRC_BIT_PORT_E];
  assign PORT_D_RESET          = pd_val[`PSRC_BIT_PORT_D];
  assign PORT_C_RESET          = pd_val[`PSRC_BIT_PORT_C];
  assign PORT_B_RESET          = pd_val[`PSRC_BIT_PORT_B];
  assign PORT_A_RESET          = pd_val[`PSRC_BIT_PORT_A];

  // Checks, all on the rising CLK edge. Properties that compare against
  // a write are disabled while RST is high: a reset edge clears the flops
  // whatever the bus is doing, so they would report false mismatches.

  // Reset leaves both words at zero one edge later
  property p_reset_zero;
    @(posedge CLK) RST |=> (st_val == `PSRC_RESET_VAL) &&
                           (pd_val == `PSRC_RESET_VAL);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

  // Reset also drops every unit line, so no unit stays held through it
  property p_reset_lines;
    @(posedge CLK) RST |=> !GP_COUNTER_TWO_RESET && !GP_COUNTER_ONE_RESET &&
                           !GP_COUNTER_ZERO_RESET && !TWOWIRE_UNIT_RESET &&
                           !SYNC_SERIAL_RESET && !ASYNC_SERIAL_RESET &&
                           !DMA_UNIT_RESET && !PORT_E_RESET &&
                           !PORT_D_RESET && !PORT_C_RESET &&
                           !PORT_B_RESET && !PORT_A_RESET;
  endproperty
  a_reset_lines: assert property (p_reset_lines)
    else $error("unit reset line high after reset");

  // A write to the first word keeps only present, implemented bits
  property p_st_mask;
    @(posedge CLK) disable iff (RST)
      wr_st |=> st_val == ($past(WDATA) & $past(CAPABILITY_MASK_SECOND)
                           & `PSRC_IMPL_ST);
  endproperty
  a_st_mask: assert property (p_st_mask)
    else $error("first register write not masked");

  // Same for the second word, against its own capability word
  property p_pd_mask;
    @(posedge CLK) disable iff (RST)
      wr_pd |=> pd_val == ($past(WDATA) & $past(CAPABILITY_MASK_FOURTH)
                           & `PSRC_IMPL_PD);
  endproperty
  a_pd_mask: assert property (p_pd_mask)
    else $error("second register write not masked");

  // An absent counter two never gets its line, whatever is written
  property p_absent_st;
    @(posedge CLK) disable iff (RST)
      wr_st && !CAPABILITY_MASK_SECOND[`PSRC_BIT_CNT2] |=>
        !GP_COUNTER_TWO_RESET;
  endproperty
  a_absent_st: assert property (p_absent_st)
    else $error("absent counter two put in reset");

  // An absent port E never gets its line, whatever is written
  property p_absent_pd;
    @(posedge CLK) disable iff (RST)
      wr_pd && !CAPABILITY_MASK_FOURTH[`PSRC_BIT_PORT_E] |=>
        !PORT_E_RESET;
  endproperty
  a_absent_pd: assert property (p_absent_pd)
    else $error("absent port E put in reset");

  // First word moves only on its own write; the reset edge is excluded
  property p_hold_st;
    @(posedge CLK) disable iff (RST)
      !RST && !wr_st |=> $stable(st_val);
  endproperty
  a_hold_st: assert property (p_hold_st)
    else $error("first register changed without a write");

  // Second word moves only on its own write; the reset edge is excluded
  property p_hold_pd;
    @(posedge CLK) disable iff (RST)
      !RST && !wr_pd |=> $stable(pd_val);
  endproperty
  a_hold_pd: assert property (p_hold_pd)
    else $error("second register changed without a write");

  // Unassigned positions never hold a one
  property p_reserved;
    @(posedge CLK) disable iff (RST)
      ((st_val & ~`PSRC_IMPL_ST) == 32'h0) &&
      ((pd_val & ~`PSRC_IMPL_PD) == 32'h0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");

  // Counter two follows bit 18 of the first word
  property p_timer_map;
    @(posedge CLK) disable iff (RST)
      wr_st |=> GP_COUNTER_TWO_RESET == $past(WDATA[18] &
                CAPABILITY_MASK_SECOND[18]);
  endproperty
  a_timer_map: assert property (p_timer_map)
    else $error("counter two reset mismatch");

  // Counters one and zero follow bits 17 and 16
  property p_timer_low;
    @(posedge CLK) disable iff (RST)
      wr_st |=> {GP_COUNTER_ONE_RESET, GP_COUNTER_ZERO_RESET} ==
                $past(WDATA[17:16] & CAPABILITY_MASK_SECOND[17:16]);
  endproperty
  a_timer_low: assert property (p_timer_low)
    else $error("counter one or zero reset mismatch");

  // Two-wire unit on bit 12, asynchronous serial unit on bit 0
  property p_serial_map;
    @(posedge CLK) disable iff (RST)
      wr_st |=> (TWOWIRE_UNIT_RESET == $past(WDATA[12] &
                 CAPABILITY_MASK_SECOND[12])) &&
                (ASYNC_SERIAL_RESET == $past(WDATA[0] &
                 CAPABILITY_MASK_SECOND[0]));
  endproperty
  a_serial_map: assert property (p_serial_map)
    else $error("serial reset mismatch");

  // Synchronous serial unit on bit 4
  property p_sync_map;
    @(posedge CLK) disable iff (RST)
      wr_st |=> SYNC_SERIAL_RESET == $past(WDATA[4] &
                CAPABILITY_MASK_SECOND[4]);
  endproperty
  a_sync_map: assert property (p_sync_map)
    else $error("sync serial reset mismatch");

  // DMA on bit 13 and port E on bit 4 of the second word
  property p_dma_map;
    @(posedge CLK) disable iff (RST)
      wr_pd |=> (DMA_UNIT_RESET == $past(WDATA[13] &
                 CAPABILITY_MASK_FOURTH[13])) &&
                (PORT_E_RESET == $past(WDATA[4] &
                 CAPABILITY_MASK_FOURTH[4]));
  endproperty
  a_dma_map: assert property (p_dma_map)
    else $error("dma or port reset mismatch");

  // Ports D down to A on bits 3 down to 0
  property p_port_map;
    @(posedge CLK) disable iff (RST)
      wr_pd |=> {PORT_D_RESET, PORT_C_RESET, PORT_B_RESET, PORT_A_RESET} ==
                $past(WDATA[3:0] & CAPABILITY_MASK_FOURTH[3:0]);
  endproperty
  a_port_map: assert property (p_port_map)
    else $error("port reset mismatch");

  // Writing a zero releases the unit on the next edge
  property p_release;
    @(posedge CLK) disable iff (RST)
      wr_st && !WDATA[`PSRC_BIT_ASYNC] |=> !ASYNC_SERIAL_RESET;
  endproperty
  a_release: assert property (p_release)
    else $error("async serial unit not released");

  // A held unit stays held until its word is written again
  property p_held;
    @(posedge CLK) disable iff (RST)
      !RST && !wr_pd && DMA_UNIT_RESET |=> DMA_UNIT_RESET;
  endproperty
  a_held: assert property (p_held)
    else $error("dma unit released without a write");

  // Read of the second word returns what stood at the strobe
  property p_read;
    @(posedge CLK) disable iff (RST)
      RD && ADDR == `PSRC_OFF_PORTS_DMA |=> RDATA == $past(pd_val);
  endproperty
  a_read: assert property (p_read)
    else $error("read data mismatch");

  // Read of the first word returns what stood at the strobe
  property p_read_st;
    @(posedge CLK) disable iff (RST)
      RD && ADDR == `PSRC_OFF_SERIAL_TIMER |=> RDATA == $past(st_val);
  endproperty
  a_read_st: assert property (p_read_st)
    else $error("first register read mismatch");

  // Reads of unmapped places return zero
  property p_read_unmapped;
    @(posedge CLK) disable iff (RST)
      RD && (ADDR != `PSRC_OFF_SERIAL_TIMER) &&
      (ADDR != `PSRC_OFF_PORTS_DMA) |=>
        RDATA == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  // Read data stand only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge CLK) disable iff (RST)
      !RD |=> RDATA == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");

  // Main scenarios: a live write to each word, a write under an absent
  // capability word, a read straight after a write, and a release
  c_write_st: cover property (@(posedge CLK) wr_st ##1 st_val != 32'h0);
  c_write_pd: cover property (@(posedge CLK) wr_pd ##1 pd_val != 32'h0);
  c_absent: cover property (@(posedge CLK)
    wr_st && CAPABILITY_MASK_SECOND == 32'h0000_0000);
  c_back_to_back: cover property (@(posedge CLK) wr_pd ##1 RD);
  c_release: cover property (@(posedge CLK) $fell(DMA_UNIT_RESET));
endmodule : psrc_top

// File: verification/psrc_units.sv
// Purpose: Model of the peripheral units fed by the reset bank
// Assumes: Active-high reset lines, one per unit
// Notes:   Reports which units are currently held in reset
module psrc_units (
  input  wire logic [11:0] reset_lines,
  output logic      [11:0] held
);
  timeunit 1ns;
  timeprecision 1ps;
  // A unit stays in reset for as long as its line is high
  assign held = reset_lines;
endmodule : psrc_units

// File: verification/tb.sv
// Purpose: Self-checking bench of the soft reset bank
// Assumes: Capability words driven as plain levels
// Notes:   Single-bit sweep and row table first, then unmapped, mask, no-gap and reset cases
`include "psrc_defines.svh"
module tb
  import psrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {psrc_addr_t a; psrc_word_t d, c, e;} psrc_row_s;
  logic        clk, rst, wr, rd;
  psrc_addr_t  addr;
  psrc_word_t  wdata, rdata, cap2, cap4, st_m, pd_m;
  logic [11:0] lines, held;
  int          fails = 0, checked = 0;
  // Address, data, capability word, expected readback
  psrc_row_s rows[4] = '{
    '{12'h044, 32'hFFFF_FFFF, 32'h0005_0010, 32'h0005_0010},
    '{12'h048, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_201F},
    '{12'h048, 32'h0000_2015, 32'h0000_0005, 32'h0000_0005},
    '{12'h044, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000}};
  psrc_top psrc_top_i (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CAPABILITY_MASK_SECOND(cap2), .CAPABILITY_MASK_FOURTH(cap4),
    .GP_COUNTER_TWO_RESET(lines[11]), .GP_COUNTER_ONE_RESET(lines[10]),
    .GP_COUNTER_ZERO_RESET(lines[9]), .TWOWIRE_UNIT_RESET(lines[8]),
    .SYNC_SERIAL_RESET(lines[7]), .ASYNC_SERIAL_RESET(lines[6]),
    .DMA_UNIT_RESET(lines[5]), .PORT_E_RESET(lines[4]),
    .PORT_D_RESET(lines[3]), .PORT_C_RESET(lines[2]),
    .PORT_B_RESET(lines[1]), .PORT_A_RESET(lines[0]));
  psrc_units psrc_units_i (.reset_lines(lines), .held(held));
  // Which units the two register words should hold in reset
  function automatic logic [11:0] exp_lines(psrc_word_t s, psrc_word_t p);
    return {s[18], s[17], s[16], s[12], s[4], s[0], p[13], p[4:0]};
  endfunction : exp_lines
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic chk_lines(string n, logic [11:0] e, logic [11:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk_lines
  // Write, then read back; data only in the cycle after the strobe
  task automatic step(psrc_addr_t a, psrc_word_t d, psrc_word_t e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == `PSRC_OFF_SERIAL_TIMER) st_m = e;
    if (a == `PSRC_OFF_PORTS_DMA) pd_m = e;
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk);
    #1 chk("rdata idle", 32'h0000_0000, rdata);
    chk_lines("held", exp_lines(st_m, pd_m), held);
  endtask : step
  task automatic summarize;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    {rst, wr, rd, addr, wdata} = '0;
    rst = 1'b1;
    {cap2, cap4, st_m, pd_m} = {32'hFFFF_FFFF, 32'hFFFF_FFFF, 64'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 chk_lines("held after reset", 12'h000, held);
    // Each bit alone, with every unit present
    for (int i = 0; i < 32; i++) begin
      step(`PSRC_OFF_SERIAL_TIMER, 32'h1 << i,
           (32'h1 << i) & `PSRC_IMPL_ST);
      step(`PSRC_OFF_PORTS_DMA, 32'h1 << i,
           (32'h1 << i) & `PSRC_IMPL_PD);
    end
    foreach (rows[i]) begin
      @(posedge clk);
      cap2 <= rows[i].c;
      cap4 <= rows[i].c;
      step(rows[i].a, rows[i].d, rows[i].e);
    end
    // Unmapped place: write ignored, reads zero, outputs unchanged
    step(12'h04C, 32'hFFFF_FFFF, 32'h0000_0000);
    // Capability words apart: each word obeys only its own mask
    step(`PSRC_OFF_SERIAL_TIMER, 32'hFFFF_FFFF, 32'h0007_1011);
    @(posedge clk);
    cap2 <= 32'h0000_0000;
    cap4 <= 32'h0000_2001;
    step(`PSRC_OFF_SERIAL_TIMER, 32'hFFFF_FFFF, 32'h0000_0000);
    step(`PSRC_OFF_PORTS_DMA, 32'hFFFF_FFFF, 32'h0000_2001);
    @(posedge clk);
    cap2 <= 32'hFFFF_FFFF;
    cap4 <= 32'hFFFF_FFFF;
    // Write then read with no gap: the read sees the new word
    @(posedge clk);
    addr  <= `PSRC_OFF_PORTS_DMA;
    wdata <= 32'h0000_0012;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    pd_m = 32'h0000_0012;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata no gap", 32'h0000_0012, rdata);
    chk_lines("held no gap", exp_lines(st_m, pd_m), held);
    // Reset in mid-run clears a live register
    step(`PSRC_OFF_SERIAL_TIMER, 32'hFFFF_FFFF, 32'h0007_1011);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    st_m = 32'h0;
    pd_m = 32'h0;
    step(12'h04C, 32'h0, 32'h0);
    step(`PSRC_OFF_PORTS_DMA, 32'h0, 32'h0);
    summarize();
  end
endmodule : tb
